// ===== local_app_model.sv
// Purpose: Local target logic model facing the bridge
// Assumes: Its ready output changes on the falling clock edge; counts and write captures change on the rising
// Notes: Read words count up from rd_base; slow halves the ready rate
`timescale 1ns/1ps
module local_app_model #(
  parameter logic [63:0] RD_BASE = 64'h5A5A_0000_0000_0000
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic tgt_select_strobe_n,
  input wire logic tgt_low_xfer_n,
  input wire logic tgt_high_xfer_n,
  input wire logic [63:0] tgt_write_bus,
  input wire logic [7:0] tgt_byte_lanes,
  output logic [63:0] tgt_read_bus,
  output logic tgt_side_ready_n,
  output logic [63:0] wr_last,
  output logic [7:0] lanes_last,
  output logic [15:0] low_cnt,
  output logic [15:0] high_cnt
);
  logic tog;
  logic [63:0] word;
  // A strobe now means the word offered last edge is gone
  assign word = RD_BASE + 64'(low_cnt) + 64'(!tgt_low_xfer_n);
  // Inverted when not ready, so a stale word never matches by luck
  assign tgt_read_bus = tgt_side_ready_n ? ~word : word;
  always @(negedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tog <= 1'b0;
      tgt_side_ready_n <= 1'b1;
    end
    else
    begin
      tog <= !tog;
      tgt_side_ready_n <= !(!tgt_select_strobe_n && (!slow || tog));
    end
  end
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_cnt <= 16'h0000;
      high_cnt <= 16'h0000;
      wr_last <= 64'h0000_0000_0000_0000;
      lanes_last <= 8'h00;
    end
    else
    begin
      if (!tgt_low_xfer_n)
      begin
        low_cnt <= low_cnt + 16'h0001;
        wr_last <= tgt_write_bus;
        lanes_last <= tgt_byte_lanes;
      end
      if (!tgt_high_xfer_n)
        high_cnt <= high_cnt + 16'h0001;
    end
  end
endmodule

// ===== pci_local_bus_interface.sv
// How it works
// - Zero window parameter becomes unused pattern; its register reads as zero.
// - Memory window bit0 is zero; bits 2:1 give 32 or 64-bit space.
// - Memory window bit3 reports prefetchable.
// - I/O window bit0 one, bit1 zero, size mask in bits 31:2.
// - All-ones write reads back size mask, 2 GB down to 4 bytes.
// - Eight and four byte sizes exist only for I/O windows.
// - Valid access asserts select strobe with one hit and the command.
// - Special Cycle produces no window hit.
// - Read data taken and transfer strobe given after target ready.
// - Burst read strobes every clock while local side adds no waits and the read buffer has room.
// - Write data driven with transfer strobe when local side is ready.
// - Wide target bus uses low and high strobes together.
// - Access end drops the select strobe and every hit.
// - Narrow window uses only low lanes and low strobe; write data passes on all bits.
// - Bus grant produces the local grant strobe.
// - Phase steps Termination, Address Loading, Transaction, Termination.
// - Wide master bus drives low and high master strobes together.
// - Bus request follows a detected narrow request by one clock.
// - Address Loading follows the clock where request and grant held.
// Purpose: Local target and local master sides of a PCI interface core
// Assumes: PCI-side engine gives decoded access and data-phase handshakes
// Notes: Window words are read through win_rd_sel; no bus is added
`timescale 1ns/1ps
module pci_local_bus_interface #(
  parameter int NWIN = 6,
  parameter int DW = 64,
  parameter int BLW = 8,
  parameter logic [31:0] WIN0 = 32'hFFFF_0000,
  parameter logic [31:0] WIN1 = 32'h0000_0000,
  parameter logic [31:0] WIN2 = 32'h0000_0000,
  parameter logic [31:0] WIN3 = 32'h0000_0000,
  parameter logic [31:0] WIN4 = 32'h0000_0000,
  parameter logic [31:0] WIN5 = 32'h0000_0000
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pci_access,
  input wire logic [3:0] pci_cmd,
  input wire logic [NWIN-1:0] pci_win_dec,
  input wire logic pci_cap_dec,
  input wire logic pci_rom_dec,
  input wire logic pci_wide,
  input wire logic pci_phase_ok,
  input wire logic [DW-1:0] pci_wr_data,
  input wire logic [7:0] pci_wr_lanes,
  output logic pci_rd_valid,
  output logic [DW-1:0] pci_rd_data,
  input wire logic pci_rd_take,
  input wire logic [2:0] win_rd_sel,
  input wire logic win_wr_ones,
  output logic [31:0] win_rd_word,
  output logic tgt_select_strobe_n,
  output logic [NWIN-1:0] tgt_window_hit,
  output logic tgt_cap_hit,
  output logic tgt_rom_hit,
  output logic [3:0] tgt_cmd_view,
  input wire logic [DW-1:0] tgt_read_bus,
  input wire logic tgt_side_ready_n,
  output logic tgt_low_xfer_n,
  output logic tgt_high_xfer_n,
  output logic [DW-1:0] tgt_write_bus,
  output logic [7:0] tgt_byte_lanes,
  input wire logic mst_narrow_request_n,
  input wire logic mst_wide_request_n,
  input wire logic [3:0] mst_cmd_lanes,
  input wire logic [31:0] mst_addr,
  input wire logic [BLW-1:0] mst_burst_words,
  input wire logic pci_gnt_n,
  input wire logic pci_last_done,
  output logic pci_req_n,
  output logic mst_granted_n,
  output logic [3:0] mst_phase,
  output logic mst_low_xfer_n,
  output logic mst_high_xfer_n,
  output logic [31:0] mst_addr_q,
  output logic [3:0] mst_cmd_q,
  output logic [BLW-1:0] mst_len_q,
  output logic mst_wide_q
);
  localparam logic [31:0] WIN_P [6] = '{WIN0, WIN1, WIN2, WIN3, WIN4, WIN5};
  if (NWIN != 6 || (DW != 32 && DW != 64) || BLW < 1)
  begin : g_bad_geometry
    $error("unsupported geometry");
  end
  logic [31:0] win_cfg [NWIN];
  logic [NWIN-1:0] win_used;
  genvar g;
  generate
    for (g = 0; g < NWIN; g++)
    begin : g_win
      // Zero parameter stands for an unused window
      assign win_used[g] = WIN_P[g] != pci_local_pkg::WIN_ZERO;
      assign win_cfg[g] = win_used[g] ? WIN_P[g] : pci_local_pkg::WIN_UNUSED;
    end
  endgenerate
  typedef struct packed {
    logic sel_n;
    logic [NWIN-1:0] hit;
    logic cap;
    logic rom;
    logic [3:0] cmd;
    logic lo_n;
    logic hi_n;
    logic [DW-1:0] wdata;
    logic [7:0] lanes;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic [NWIN-1:0] sized;
    logic [31:0] rword;
    logic req_n;
    logic gnt_n;
    pci_local_pkg::mst_phase_type ph;
    logic mlo_n;
    logic mhi_n;
    logic [31:0] maddr;
    logic [3:0] mcmd;
    logic [BLW-1:0] mlen;
    logic mwide;
  } core_state_type;
  core_state_type st_r;
  core_state_type st_nxt;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [DW-1:0] buf_out_data;
  logic is_read;
  logic is_write;
  logic narrow_win;
  logic any_req;
  logic [31:0] wsel;
  assign is_read = st_r.cmd == pci_local_pkg::CMD_MEM_READ;
  assign is_write = st_r.cmd == pci_local_pkg::CMD_MEM_WRITE;
  assign narrow_win = DW == 32 || !pci_wide;
  assign any_req = !mst_narrow_request_n || !mst_wide_request_n;
  assign wsel = win_cfg[3'(win_rd_sel) % 3'(NWIN)];
  // Push only where a read strobe goes out, so words and strobes pair one to one
  skid_buf #(.WIDTH(DW)) u_rd_buf (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(!st_r.sel_n && pci_access && is_read && !tgt_side_ready_n),
    .in_ready(buf_in_ready),
    .in_data(tgt_read_bus),
    .out_valid(buf_out_valid),
    .out_ready(pci_rd_take),
    .out_data(buf_out_data)
  );
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.lo_n = 1'b1;
    st_nxt.hi_n = 1'b1;
    st_nxt.mlo_n = 1'b1;
    st_nxt.mhi_n = 1'b1;
    st_nxt.rdata = buf_out_data;
    st_nxt.rvalid = buf_out_valid && !pci_rd_take;
    if (pci_access)
    begin
      st_nxt.sel_n = 1'b0;
      st_nxt.cmd = pci_cmd;
      if (pci_cmd == pci_local_pkg::CMD_SPECIAL)
        st_nxt.hit = '0;
      else
        st_nxt.hit = pci_win_dec & win_used;
      st_nxt.cap = pci_cap_dec && pci_cmd != pci_local_pkg::CMD_SPECIAL;
      st_nxt.rom = pci_rom_dec && pci_cmd != pci_local_pkg::CMD_SPECIAL;
    end
    else
    begin
      st_nxt.sel_n = 1'b1;
      st_nxt.hit = '0;
      st_nxt.cap = 1'b0;
      st_nxt.rom = 1'b0;
    end
    // Read: strobe each clock the local side is ready and buffer has room
    if (!st_r.sel_n && pci_access && is_read && !tgt_side_ready_n && buf_in_ready)
    begin
      st_nxt.lo_n = 1'b0;
      st_nxt.hi_n = narrow_win;
    end
    if (!st_r.sel_n && pci_access && is_write && !tgt_side_ready_n && pci_phase_ok)
    begin
      st_nxt.lo_n = 1'b0;
      st_nxt.hi_n = narrow_win;
      st_nxt.wdata = pci_wr_data;
      st_nxt.lanes = narrow_win ? {4'h0, pci_wr_lanes[3:0]} : pci_wr_lanes;
    end
    // Size mask read-back after all-ones probe; unused windows read zero
    if (win_wr_ones)
      st_nxt.sized[win_rd_sel % 3'(NWIN)] = 1'b1;
    if (!win_used[win_rd_sel % 3'(NWIN)])
      st_nxt.rword = pci_local_pkg::WIN_ZERO;
    else if (st_r.sized[win_rd_sel % 3'(NWIN)])
    begin
      if (wsel[pci_local_pkg::WIN_KIND_BIT])
        st_nxt.rword = {wsel[31:2], 2'b01};
      else
        st_nxt.rword = {wsel[31:4], wsel[3], wsel[2:1] & 2'b10, 1'b0};
    end
    else
      st_nxt.rword = pci_local_pkg::WIN_ZERO;
    st_nxt.req_n = st_r.ph == pci_local_pkg::PH_TERM ? !any_req : 1'b1;
    st_nxt.gnt_n = !(!pci_gnt_n && !st_r.req_n);
    case (st_r.ph)
      pci_local_pkg::PH_TERM:
      begin
        if (any_req && !pci_gnt_n && !st_r.req_n)
        begin
          st_nxt.ph = pci_local_pkg::PH_ADDR;
          st_nxt.maddr = mst_addr;
          st_nxt.mcmd = mst_cmd_lanes;
          st_nxt.mlen = mst_burst_words;
          st_nxt.mwide = !mst_wide_request_n && DW == 64;
        end
      end
      pci_local_pkg::PH_ADDR:
        st_nxt.ph = pci_local_pkg::PH_XFER;
      pci_local_pkg::PH_XFER:
      begin
        if (pci_phase_ok)
        begin
          st_nxt.mlo_n = 1'b0;
          st_nxt.mhi_n = !st_r.mwide;
        end
        if (pci_last_done)
          st_nxt.ph = pci_local_pkg::PH_TERM;
      end
      default:
        st_nxt.ph = pci_local_pkg::PH_TERM;
    endcase
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.sel_n <= 1'b1;
      st_r.lo_n <= 1'b1;
      st_r.hi_n <= 1'b1;
      st_r.req_n <= 1'b1;
      st_r.gnt_n <= 1'b1;
      st_r.mlo_n <= 1'b1;
      st_r.mhi_n <= 1'b1;
      st_r.ph <= pci_local_pkg::PH_TERM;
    end
    else
      st_r <= st_nxt;
  end
  // Output ports straight from the state register
  assign pci_rd_valid = st_r.rvalid;
  assign pci_rd_data = st_r.rdata;
  assign win_rd_word = st_r.rword;
  assign tgt_select_strobe_n = st_r.sel_n;
  assign tgt_window_hit = st_r.hit;
  assign tgt_cap_hit = st_r.cap;
  assign tgt_rom_hit = st_r.rom;
  assign tgt_cmd_view = st_r.cmd;
  assign tgt_low_xfer_n = st_r.lo_n;
  assign tgt_high_xfer_n = st_r.hi_n;
  assign tgt_write_bus = st_r.wdata;
  assign tgt_byte_lanes = st_r.lanes;
  assign pci_req_n = st_r.req_n;
  assign mst_granted_n = st_r.gnt_n;
  assign mst_phase = st_r.ph;
  assign mst_low_xfer_n = st_r.mlo_n;
  assign mst_high_xfer_n = st_r.mhi_n;
  assign mst_addr_q = st_r.maddr;
  assign mst_cmd_q = st_r.mcmd;
  assign mst_len_q = st_r.mlen;
  assign mst_wide_q = st_r.mwide;
  a_hits_end_access: assert property (@(posedge sys_clk) disable iff (!nrst)
    tgt_select_strobe_n |-> (tgt_window_hit == '0 && !tgt_cap_hit && !tgt_rom_hit))
    else $error("hit without access");
  a_special_no_hit: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!tgt_select_strobe_n && tgt_cmd_view == pci_local_pkg::CMD_SPECIAL) |-> tgt_window_hit == '0)
    else $error("window hit on special cycle");
  a_access_select: assert property (@(posedge sys_clk) disable iff (!nrst)
    pci_access |=> !tgt_select_strobe_n && tgt_cmd_view == $past(pci_cmd))
    else $error("select strobe missing");
  a_read_after_ready: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!tgt_low_xfer_n && tgt_cmd_view == pci_local_pkg::CMD_MEM_READ) |-> $past(!tgt_side_ready_n))
    else $error("read strobe without ready");
  a_high_needs_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    !tgt_high_xfer_n |-> !tgt_low_xfer_n) else $error("high strobe alone");
  a_phase_walk: assert property (@(posedge sys_clk) disable iff (!nrst)
    mst_phase == pci_local_pkg::PH_ADDR |=> mst_phase == pci_local_pkg::PH_XFER)
    else $error("phase skipped");
  a_req_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!mst_narrow_request_n && mst_phase == pci_local_pkg::PH_TERM) |=> !pci_req_n)
    else $error("bus request late");
  a_addr_load: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mst_phase == pci_local_pkg::PH_TERM && !pci_req_n && !pci_gnt_n && !mst_narrow_request_n)
    |=> mst_phase == pci_local_pkg::PH_ADDR && mst_addr_q == $past(mst_addr))
    else $error("address not loaded");
  a_mst_xfer_phase: assert property (@(posedge sys_clk) disable iff (!nrst)
    !mst_low_xfer_n |-> $past(mst_phase == pci_local_pkg::PH_XFER))
    else $error("master strobe outside transaction");
  c_burst_read: cover property (@(posedge sys_clk) disable iff (!nrst)
    !tgt_low_xfer_n [*3]);
  c_master_cycle: cover property (@(posedge sys_clk) disable iff (!nrst)
    mst_phase == pci_local_pkg::PH_ADDR ##1 mst_phase == pci_local_pkg::PH_XFER);
  c_write_xfer: cover property (@(posedge sys_clk) disable iff (!nrst)
    !tgt_low_xfer_n && tgt_cmd_view == pci_local_pkg::CMD_MEM_WRITE);
endmodule

// ===== pci_local_pkg.sv
// Purpose: Shared constants for the local-side bridge of the bus interface
// Assumes: One bus clock shared by the PCI side and both local sides
// Notes: Window encodings and master phase codes live here
package pci_local_pkg;
  localparam logic [31:0] WIN_UNUSED = 32'h0000_0002;
  localparam logic [31:0] WIN_ZERO = 32'h0000_0000;
  localparam int WIN_KIND_BIT = 0;
  localparam int WIN_TYPE_LSB = 1;
  localparam int WIN_PREF_BIT = 3;
  localparam logic [1:0] WIN_TYPE_32 = 2'h0;
  localparam logic [1:0] WIN_TYPE_64 = 2'h2;
  localparam logic [31:0] IO_SIZE_8 = 32'hFFFF_FFF9;
  localparam logic [31:0] IO_SIZE_4 = 32'hFFFF_FFFD;
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  typedef enum logic [3:0] {
    PH_TERM = 4'b0000,
    PH_ADDR = 4'b0001,
    PH_XFER = 4'b0010
  } mst_phase_type;
endpackage

// ===== skid_buf.sv
// Purpose: Two-entry valid/ready buffer in the target read data path
// Assumes: Synchronous use, active-low asynchronous reset
// Notes: Full only when both entries hold data
`timescale 1ns/1ps
module skid_buf #(
  parameter int WIDTH = 64
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] cnt;
  } skid_state_type;
  skid_state_type st_r;
  skid_state_type st_nxt;
  logic push;
  logic pop;
  assign in_ready = st_r.cnt != 2'd2;
  assign out_valid = st_r.cnt != 2'd0;
  assign out_data = st_r.mem[0];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb
  begin
    st_nxt = st_r;
    if (pop)
    begin
      st_nxt.mem[0] = st_r.mem[1];
    end
    if (push)
    begin
      if (st_r.cnt == 2'd0 || (st_r.cnt == 2'd1 && pop))
        st_nxt.mem[0] = in_data;
      else
        st_nxt.mem[1] = in_data;
    end
    st_nxt.cnt = 2'(st_r.cnt + {1'b0, push} - {1'b0, pop});
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  a_never_over: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_r.cnt <= 2'd2) else $error("buffer count over two");
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the local-side bridge
// Assumes: Inputs driven on the falling edge; far target side is the model
// Notes: Window and decode cases are table rows; the rest is hand-written
`timescale 1ns/1ps
module testbench;
  localparam logic [63:0] RD_BASE = 64'h5A5A_0000_0000_0000;
  // Unused window left at zero; total window space stays under 4 GB
  localparam logic [31:0] WEXP [6] = '{32'hFFFF_000C, 32'h0000_0000, 32'hFFFF_FFF9,
    32'hFFFF_FFFD, 32'h8000_0000, 32'hFFFF_FF01};
  localparam logic [3:0] DCMD [5] = '{4'h6, 4'h7, 4'h1, 4'h6, 4'h6};
  localparam logic [5:0] DWIN [5] = '{6'h01, 6'h04, 6'h01, 6'h00, 6'h00};
  localparam logic [1:0] DCR [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  localparam logic [5:0] XWIN [5] = '{6'h01, 6'h04, 6'h00, 6'h00, 6'h00};
  logic sys_clk, nrst, pci_access, pci_cap_dec, pci_rom_dec, pci_wide, pci_phase_ok;
  logic [3:0] pci_cmd, tgt_cmd_view, mst_cmd_lanes, mst_phase, mst_cmd_q;
  logic [5:0] pci_win_dec, tgt_window_hit;
  logic [63:0] pci_wr_data, pci_rd_data, tgt_read_bus, tgt_write_bus, wr_last;
  logic [7:0] pci_wr_lanes, tgt_byte_lanes, mst_burst_words, mst_len_q, lanes_last;
  logic pci_rd_valid, pci_rd_take, win_wr_ones, tgt_select_strobe_n, tgt_cap_hit, tgt_rom_hit;
  logic [2:0] win_rd_sel;
  logic [31:0] win_rd_word, mst_addr, mst_addr_q;
  logic tgt_side_ready_n, tgt_low_xfer_n, tgt_high_xfer_n, mst_narrow_request_n;
  logic mst_wide_request_n, pci_gnt_n, pci_last_done, pci_req_n, mst_granted_n;
  logic mst_low_xfer_n, mst_high_xfer_n, mst_wide_q, slow;
  logic [15:0] low_cnt, high_cnt;
  int err_total = 0;
  int samples_checked = 0;
  int i;
  pci_local_bus_interface #(.WIN0(WEXP[0]), .WIN1(WEXP[1]), .WIN2(WEXP[2]), .WIN3(WEXP[3]),
    .WIN4(WEXP[4]), .WIN5(WEXP[5])) dut (.sys_clk(sys_clk), .nrst(nrst),
    .pci_access(pci_access), .pci_cmd(pci_cmd), .pci_win_dec(pci_win_dec),
    .pci_cap_dec(pci_cap_dec), .pci_rom_dec(pci_rom_dec), .pci_wide(pci_wide),
    .pci_phase_ok(pci_phase_ok), .pci_wr_data(pci_wr_data), .pci_wr_lanes(pci_wr_lanes),
    .pci_rd_valid(pci_rd_valid), .pci_rd_data(pci_rd_data), .pci_rd_take(pci_rd_take),
    .win_rd_sel(win_rd_sel), .win_wr_ones(win_wr_ones), .win_rd_word(win_rd_word),
    .tgt_select_strobe_n(tgt_select_strobe_n), .tgt_window_hit(tgt_window_hit),
    .tgt_cap_hit(tgt_cap_hit), .tgt_rom_hit(tgt_rom_hit), .tgt_cmd_view(tgt_cmd_view),
    .tgt_read_bus(tgt_read_bus), .tgt_side_ready_n(tgt_side_ready_n),
    .tgt_low_xfer_n(tgt_low_xfer_n), .tgt_high_xfer_n(tgt_high_xfer_n),
    .tgt_write_bus(tgt_write_bus), .tgt_byte_lanes(tgt_byte_lanes),
    .mst_narrow_request_n(mst_narrow_request_n), .mst_wide_request_n(mst_wide_request_n),
    .mst_cmd_lanes(mst_cmd_lanes), .mst_addr(mst_addr), .mst_burst_words(mst_burst_words),
    .pci_gnt_n(pci_gnt_n), .pci_last_done(pci_last_done), .pci_req_n(pci_req_n),
    .mst_granted_n(mst_granted_n), .mst_phase(mst_phase), .mst_low_xfer_n(mst_low_xfer_n),
    .mst_high_xfer_n(mst_high_xfer_n), .mst_addr_q(mst_addr_q), .mst_cmd_q(mst_cmd_q),
    .mst_len_q(mst_len_q), .mst_wide_q(mst_wide_q));
  local_app_model #(.RD_BASE(RD_BASE)) app (.sys_clk(sys_clk), .nrst(nrst), .slow(slow),
    .tgt_select_strobe_n(tgt_select_strobe_n), .tgt_low_xfer_n(tgt_low_xfer_n),
    .tgt_high_xfer_n(tgt_high_xfer_n), .tgt_write_bus(tgt_write_bus),
    .tgt_byte_lanes(tgt_byte_lanes), .tgt_read_bus(tgt_read_bus),
    .tgt_side_ready_n(tgt_side_ready_n), .wr_last(wr_last), .lanes_last(lanes_last),
    .low_cnt(low_cnt), .high_cnt(high_cnt));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = !sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic mst_run(input logic wide, input logic [31:0] a);
    // Request only in Bus Termination, with address, command, length alongside
    mst_narrow_request_n = wide;
    mst_wide_request_n = !wide;
    mst_addr = a;
    for (i = 0; i < 8 && pci_req_n !== 1'b0; i++) tick(1);
    chk("pci_req_n", pci_req_n, 64'h0);
    pci_gnt_n = 1'b0;
    for (i = 0; i < 8 && mst_phase !== pci_local_pkg::PH_ADDR; i++) tick(1);
    chk("mst_phase", mst_phase, pci_local_pkg::PH_ADDR);
    chk("mst_granted_n", mst_granted_n, 64'h0);
    chk("mst_q", {mst_wide_q, mst_len_q, mst_cmd_q, mst_addr_q}, {wide, 8'h04, 4'h6, a});
    mst_narrow_request_n = 1'b1;
    mst_wide_request_n = 1'b1;
    pci_gnt_n = 1'b1;
    tick(1);
    chk("mst_phase", mst_phase, pci_local_pkg::PH_XFER);
    pci_phase_ok = 1'b1;
    for (i = 0; i < 8 && mst_low_xfer_n !== 1'b0; i++) tick(1);
    chk("mst_xfer", {mst_low_xfer_n, mst_high_xfer_n}, {1'b0, !wide});
    pci_phase_ok = 1'b0;
    pci_last_done = 1'b1;
    for (i = 0; i < 8 && mst_phase !== pci_local_pkg::PH_TERM; i++) tick(1);
    chk("mst_phase", mst_phase, pci_local_pkg::PH_TERM);
    pci_last_done = 1'b0;
    tick(2);
  endtask
  initial
  begin
    #60000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    {nrst, pci_access, pci_cap_dec, pci_rom_dec, pci_wide, pci_phase_ok, slow} = 7'h00;
    {pci_rd_take, win_wr_ones, pci_last_done, win_rd_sel, pci_cmd, pci_win_dec} = 16'h0000;
    {mst_narrow_request_n, mst_wide_request_n, pci_gnt_n} = 3'h7;
    {mst_cmd_lanes, mst_burst_words, mst_addr} = {4'h6, 8'h04, 32'h0000_0000};
    pci_wr_data = 64'hDEAD_BEEF_0123_4567;
    pci_wr_lanes = 8'hFF;
    tick(12);
    nrst = 1'b1;
    chk("reset", {tgt_select_strobe_n, tgt_low_xfer_n, mst_granted_n, mst_phase},
      7'h70);
    for (int r = 0; r < 6; r++)
    begin
      win_rd_sel = 3'(r);
      win_wr_ones = 1'b1;
      tick(1);
      win_wr_ones = 1'b0;
      tick(2);
      chk("win_rd_word", win_rd_word, WEXP[r]);
    end
    $display("test windows done");
    for (int r = 0; r < 5; r++)
    begin
      {pci_cmd, pci_win_dec, pci_rom_dec, pci_cap_dec} = {DCMD[r], DWIN[r], DCR[r]};
      pci_access = 1'b1;
      tick(2);
      chk("select", {tgt_select_strobe_n, tgt_cmd_view}, {1'b0, DCMD[r]});
      chk("hits", {tgt_window_hit, tgt_rom_hit, tgt_cap_hit}, {XWIN[r], DCR[r]});
      pci_access = 1'b0;
      tick(2);
      chk("end", {tgt_select_strobe_n, tgt_window_hit, tgt_rom_hit, tgt_cap_hit}, 9'h100);
    end
    $display("test decode done");
    {nrst, pci_cap_dec, pci_rom_dec} = 3'h0;
    tick(2);
    nrst = 1'b1;
    // Narrow write: upper lanes and high strobe must stay unused
    {pci_cmd, pci_win_dec, pci_phase_ok, pci_access} = {4'h7, 6'h04, 2'h3};
    tick(4);
    pci_access = 1'b0;
    pci_phase_ok = 1'b0;
    tick(2);
    chk("wr_low", wr_last[31:0], pci_wr_data[31:0]);
    chk("lanes", lanes_last, 8'h0F);
    chk("low_cnt", low_cnt, 16'h0003);
    chk("high_cnt", high_cnt, 16'h0000);
    $display("test write done");
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    // Wide read against a slow side, engine stalled until the buffer refuses
    {slow, pci_wide, pci_cmd, pci_win_dec, pci_access} = {2'h3, 4'h6, 6'h01, 1'b1};
    tick(16);
    chk("low_high", high_cnt, low_cnt);
    chk("low_cnt", low_cnt, 16'h0002);
    for (int n = 0; n < 4; n++)
    begin
      for (i = 0; i < 20 && pci_rd_valid !== 1'b1; i++) tick(1);
      chk("pci_rd_valid", pci_rd_valid, 64'h1);
      chk("pci_rd_data", pci_rd_data, RD_BASE + 64'(n));
      pci_rd_take = 1'b1;
      tick(1);
      pci_rd_take = 1'b0;
      tick(2);
    end
    pci_access = 1'b0;
    tick(3);
    $display("test read done");
    mst_run(1'b0, 32'h1000_0040);
    mst_run(1'b1, 32'h2000_0080);
    $display("test master done");
    end_of_test();
  end
endmodule
